// [include/stepper_drive_map.svh]
`ifndef STEPPER_DRIVE_MAP_SVH
`define STEPPER_DRIVE_MAP_SVH

// ============================================================
// register offsets on the plain software port
`define CTRL_OFFSET 4'h0
`define SETTINGS_OFFSET 4'h4
`define RATE_OFFSET 4'h8
`define BACKLOG_OFFSET 4'hc

// ============================================================
// field position and reset value
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET_VALUE 1'b1

// ============================================================
// resolution base values in steps per revolution, and the times-ten factor
`define RES_FINE_BASE 14'd1000
`define RES_COARSE_BASE 14'd500
`define RES_TIMES_TEN 14'd10

// ============================================================
// timing and switch defaults
`define CLK_MHZ 20
`define TICK_SHIFT 6
`define SETTLE_CYCLES 2'd3
`define CURRENT_DEFAULT 4'hf
`define FILTER_DEFAULT 4'h6

`endif

// [include/stepper_drive_pkg.sv]
package stepper_drive_pkg;

  typedef enum logic [1:0] {
    PWR_SETTLE = 2'b00,
    PWR_LATCH = 2'b01,
    PWR_RUN = 2'b10
  } power_state_e;

  typedef enum logic {
    DUAL_PULSE_FORMAT = 1'b1,
    SINGLE_PULSE_FORMAT = 1'b0
  } pulse_format_e;

endpackage : stepper_drive_pkg

// [verilog/stepper_drive_setting_logic.sv]
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "stepper_drive_map.svh"
// How it works
// (RULE_01) resolution selectors are read once after power-up; later changes wait for a reset.
// (RULE_02) the times-ten input acts only while the base multiplier switch is at times one.
// (RULE_03) base switch gives 1000 or 500 steps, times ten gives 10000 or 5000.
// (RULE_04) the pulse format switch is read once after power-up only.
// (RULE_05) dual format takes forward steps on one pulse pin and reverse on another.
// (RULE_06) single format takes steps on one pin and the sense from a direction level.
// (RULE_07) a sixteen-position current switch scales current as a percentage of maximum.
// (RULE_08) current codes 0..f map to 6,13,19,25,31,38,44,50,56,63,69,75,81,88,94,100 percent.
// (RULE_09) the current code defaults to f, full current.
// (RULE_10) filter codes 0..f give none, 0.12 .. 82.0 ms; default code 6 is 1.20 ms.
// (RULE_11) the filter smooths the step rate with the chosen time constant.
// (RULE_12) resolution and format sit in registers loaded once, when the settle delay after reset release ends.
// (RULE_13) filter code 0 passes steps through with no added delay.
// (RULE_14) active times-ten input selects times ten, inactive selects times one while the base switch is at times one.
// (RULE_15) the reverse pulse pin counts only in dual format.
// (RULE_16) the controller keeps direction high for forward and never pulses both pins together.
module stepper_drive_setting_logic (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic res_fine_sel_in,
  input wire logic base_times_ten_sel_in,
  input wire logic times_ten_in,
  input wire logic format_sel_in,
  input wire logic [3:0] current_sel_in,
  input wire logic [3:0] rate_smoothing_sel_in,
  input wire logic forward_pulse_in,
  input wire logic reverse_pulse_in,
  input wire logic step_pulse_in,
  input wire logic direction_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [31:0] rd_data_out,
  output logic settings_ready_out,
  output logic [13:0] steps_per_rev_out,
  output logic single_pulse_format_out,
  output logic [6:0] current_pct_out,
  output logic motor_step_out,
  output logic motor_forward_out
);
  // ============================================================
  // pin synchronisers
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign pins_raw = {res_fine_sel_in, base_times_ten_sel_in, times_ten_in, format_sel_in,
                     current_sel_in, rate_smoothing_sel_in, forward_pulse_in,
                     reverse_pulse_in, step_pulse_in, direction_in};
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end
  logic s_res_fine, s_base_ten, s_ten_in, s_format, s_fwd, s_rev, s_step, s_dir;
  logic [3:0] s_current, s_filter;
  assign {s_res_fine, s_base_ten, s_ten_in, s_format, s_current, s_filter,
          s_fwd, s_rev, s_step, s_dir} = sync2_q;

  // ============================================================
  // power-up capture
  stepper_drive_pkg::power_state_e pwr_q;
  logic [1:0] settle_q;
  logic res_fine_q;
  logic base_ten_q;
  stepper_drive_pkg::pulse_format_e format_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pwr_q <= stepper_drive_pkg::PWR_SETTLE;
      settle_q <= 2'h0;
    end else begin
      case (pwr_q)
        stepper_drive_pkg::PWR_SETTLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == `SETTLE_CYCLES - 2'h1) begin
            pwr_q <= stepper_drive_pkg::PWR_LATCH;
          end
        end
        stepper_drive_pkg::PWR_LATCH: pwr_q <= stepper_drive_pkg::PWR_RUN;
        stepper_drive_pkg::PWR_RUN: pwr_q <= stepper_drive_pkg::PWR_RUN;
        default: pwr_q <= stepper_drive_pkg::PWR_SETTLE;
      endcase
    end
  end

  // settle delay lets the synchronisers fill before the switches are caught
  // (RULE_01) one-shot capture
  // (RULE_04) one-shot capture
  // (RULE_12) held until reset
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      res_fine_q <= 1'b1;
      base_ten_q <= 1'b0;
      format_q <= stepper_drive_pkg::DUAL_PULSE_FORMAT;
    end else if (pwr_q == stepper_drive_pkg::PWR_LATCH) begin
      res_fine_q <= s_res_fine;
      base_ten_q <= s_base_ten;
      format_q <= stepper_drive_pkg::pulse_format_e'(s_format);
    end
  end
  logic running;
  assign running = (pwr_q == stepper_drive_pkg::PWR_RUN);

  // ============================================================
  // resolution
  logic ten_active;
  logic [13:0] base_res;
  // (RULE_02) override only at times one
  // (RULE_14) input level picks multiplier
  assign ten_active = base_ten_q | s_ten_in;
  // (RULE_03) four resolutions
  assign base_res = res_fine_q ? `RES_FINE_BASE : `RES_COARSE_BASE;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      steps_per_rev_out <= `RES_FINE_BASE;
      settings_ready_out <= 1'b0;
      single_pulse_format_out <= 1'b0;
    end else begin
      steps_per_rev_out <= ten_active ? 14'(base_res * `RES_TIMES_TEN) : base_res;
      settings_ready_out <= running;
      single_pulse_format_out <= (format_q == stepper_drive_pkg::SINGLE_PULSE_FORMAT);
    end
  end

  // ============================================================
  // operating current
  function automatic logic [6:0] current_pct(input logic [3:0] code);
    // (RULE_08) percentage table
    case (code)
      4'h0: current_pct = 7'd6;
      4'h1: current_pct = 7'd13;
      4'h2: current_pct = 7'd19;
      4'h3: current_pct = 7'd25;
      4'h4: current_pct = 7'd31;
      4'h5: current_pct = 7'd38;
      4'h6: current_pct = 7'd44;
      4'h7: current_pct = 7'd50;
      4'h8: current_pct = 7'd56;
      4'h9: current_pct = 7'd63;
      4'ha: current_pct = 7'd69;
      4'hb: current_pct = 7'd75;
      4'hc: current_pct = 7'd81;
      4'hd: current_pct = 7'd88;
      4'he: current_pct = 7'd94;
      default: current_pct = 7'd100;
    endcase
  endfunction : current_pct
  // the switch is live: current can be trimmed while running
  // (RULE_07) sixteen-level scale
  // (RULE_09) default full current
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      current_pct_out <= current_pct(`CURRENT_DEFAULT);
    end else if (running) begin
      current_pct_out <= current_pct(s_current);
    end
  end

  // ============================================================
  // command step decode
  logic fwd_prev_q, rev_prev_q, step_prev_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      fwd_prev_q <= 1'b0;
      rev_prev_q <= 1'b0;
      step_prev_q <= 1'b0;
    end else begin
      fwd_prev_q <= s_fwd;
      rev_prev_q <= s_rev;
      step_prev_q <= s_step;
    end
  end
  logic fwd_edge, rev_edge, cmd_step, cmd_forward;
  assign fwd_edge = s_fwd & ~fwd_prev_q;
  assign rev_edge = s_rev & ~rev_prev_q;
  always_comb begin
    cmd_step = 1'b0;
    cmd_forward = 1'b1;
    if (running && format_q == stepper_drive_pkg::DUAL_PULSE_FORMAT) begin
      // (RULE_05) separate pins per sense
      // (RULE_15) reverse pin only here
      // (RULE_16) both edges at once are dropped
      cmd_step = fwd_edge ^ rev_edge;
      cmd_forward = fwd_edge;
    end else if (running) begin
      // (RULE_06) pulse plus direction level
      cmd_step = s_step & ~step_prev_q;
      cmd_forward = s_dir;
    end
  end

  // ============================================================
  // rate smoothing
  // the time constant is 64 ticks; a tick lasts tau/64, so one tick table serves all codes
  function automatic logic [14:0] tick_len(input logic [3:0] code);
    int unsigned tau_us;
    tau_us = 0;
    // (RULE_10) time constant table
    case (code)
      4'h1: tau_us = 120;
      4'h2: tau_us = 160;
      4'h3: tau_us = 270;
      4'h4: tau_us = 410;
      4'h5: tau_us = 820;
      4'h6: tau_us = 1200;
      4'h7: tau_us = 1600;
      4'h8: tau_us = 2700;
      4'h9: tau_us = 4100;
      4'ha: tau_us = 8200;
      4'hb: tau_us = 12000;
      4'hc: tau_us = 16000;
      4'hd: tau_us = 27000;
      4'he: tau_us = 41000;
      4'hf: tau_us = 82000;
      default: tau_us = 0;
    endcase
    tick_len = 15'((tau_us * `CLK_MHZ) >> `TICK_SHIFT);
  endfunction : tick_len
  logic [3:0] filt_code_q;
  logic [14:0] tick_cnt_q, win_steps_q;
  logic [21:0] rate_q;
  logic [22:0] phase_q;
  logic signed [15:0] backlog_q;
  logic [14:0] tick_max;
  logic tick, bypass, emit;
  logic [22:0] phase_sum, phase_limit;
  assign tick_max = tick_len(filt_code_q);
  assign tick = (tick_cnt_q >= tick_max - 15'h1);
  // (RULE_13) code 0 bypasses
  assign bypass = (filt_code_q == 4'h0);
  assign phase_sum = phase_q + 23'(rate_q);
  assign phase_limit = {2'b00, tick_max, 6'h00};
  assign emit = !bypass && backlog_q != 16'sh0 && phase_sum >= phase_limit;
  // code change only taken while idle so the rate estimate stays consistent
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      filt_code_q <= `FILTER_DEFAULT;
    end else if (running && backlog_q == 16'sh0 && rate_q == 22'h0) begin
      filt_code_q <= s_filter;
    end
  end
  // (RULE_11) first-order rate estimate
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_cnt_q <= 15'h0;
      win_steps_q <= 15'h0;
      rate_q <= 22'h0;
    end else if (bypass) begin
      tick_cnt_q <= 15'h0;
      win_steps_q <= 15'h0;
      rate_q <= 22'h0;
    end else if (tick) begin
      tick_cnt_q <= 15'h0;
      win_steps_q <= 15'(cmd_step);
      rate_q <= rate_q + 22'(win_steps_q) - (rate_q >> `TICK_SHIFT);
    end else begin
      tick_cnt_q <= tick_cnt_q + 15'h1;
      win_steps_q <= win_steps_q + 15'(cmd_step);
    end
  end
  // backlog wraps past 32767 steps; the filter is not meant to lag that far
  // (RULE_11) steps released at the smoothed rate
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_q <= 23'h0;
      backlog_q <= 16'sh0;
    end else if (bypass) begin
      phase_q <= 23'h0;
      backlog_q <= 16'sh0;
    end else begin
      if (backlog_q == 16'sh0) begin
        phase_q <= 23'h0;
      end else if (emit) begin
        phase_q <= phase_sum - phase_limit;
      end else begin
        phase_q <= phase_sum;
      end
      backlog_q <= backlog_q
                   + (cmd_step ? (cmd_forward ? 16'sh1 : -16'sh1) : 16'sh0)
                   - (emit ? (backlog_q > 16'sh0 ? 16'sh1 : -16'sh1) : 16'sh0);
    end
  end

  // ============================================================
  // software port
  logic enable_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      enable_q <= `CTRL_RESET_VALUE;
    end else if (wr_strobe_in && addr_in == `CTRL_OFFSET) begin
      enable_q <= wr_data_in[`CTRL_ENABLE_BIT];
    end
  end
  // disabling blocks motor steps and keeps the sense; the backlog still drains
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      motor_step_out <= 1'b0;
      motor_forward_out <= 1'b1;
    end else if (bypass) begin
      motor_step_out <= enable_q & cmd_step;
      if (cmd_step && enable_q) begin
        motor_forward_out <= cmd_forward;
      end
    end else begin
      motor_step_out <= enable_q & emit;
      if (emit && enable_q) begin
        motor_forward_out <= (backlog_q > 16'sh0);
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= 32'h0;
    end else if (rd_strobe_in) begin
      case (addr_in)
        `CTRL_OFFSET: rd_data_out <= {31'h0, enable_q};
        `SETTINGS_OFFSET: rd_data_out <= {10'h0, running, ten_active, filt_code_q,
                                          s_current, 2'h0, base_ten_q, res_fine_q,
                                          3'h0, format_q, steps_per_rev_out[3:0]};
        `RATE_OFFSET: rd_data_out <= {10'h0, rate_q};
        `BACKLOG_OFFSET: rd_data_out <= {{16{backlog_q[15]}}, backlog_q};
        default: rd_data_out <= 32'h0;
      endcase
    end else begin
      rd_data_out <= 32'h0;
    end
  end

endmodule : stepper_drive_setting_logic

// [sim/stepper_drive_chk.sv]
`timescale 1ns/1ns
module stepper_drive_chk (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic rd_strobe_in,
  input wire logic forward_pulse_in,
  input wire logic reverse_pulse_in,
  input wire logic step_pulse_in,
  input wire logic [3:0] rate_smoothing_sel_in,
  input wire logic [31:0] rd_data_out,
  input wire logic settings_ready_out,
  input wire logic [13:0] steps_per_rev_out,
  input wire logic single_pulse_format_out,
  input wire logic [6:0] current_pct_out,
  input wire logic motor_step_out,
  input wire logic motor_forward_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // ========
  // properties
  property p_rd_zero;
    !$past(rd_strobe_in) |-> rd_data_out == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside answer cycle");
  property p_res_set;
    settings_ready_out |-> steps_per_rev_out inside {14'd500, 14'd1000, 14'd5000, 14'd10000};
  endproperty
  a_res_set: assert property (p_res_set) else $error("bad resolution");
  property p_fmt_hold;
    settings_ready_out && $past(settings_ready_out) |-> $stable(single_pulse_format_out);
  endproperty
  a_fmt_hold: assert property (p_fmt_hold) else $error("format changed");
  property p_ready_hold;
    settings_ready_out |=> settings_ready_out;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
  property p_fwd_moves;
    $changed(motor_forward_out) |-> motor_step_out;
  endproperty
  a_fwd_moves: assert property (p_fwd_moves) else $error("sense moved alone");
  property p_step_one;
    motor_step_out |=> !motor_step_out;
  endproperty
  a_step_one: assert property (p_step_one) else $error("step longer than a cycle");
  property p_no_early;
    !settings_ready_out |-> !motor_step_out;
  endproperty
  a_no_early: assert property (p_no_early) else $error("step before ready");
  property p_bypass;
    settings_ready_out && !single_pulse_format_out && rate_smoothing_sel_in == 4'h0
      && $rose(forward_pulse_in) && !reverse_pulse_in |-> ##3 motor_step_out && motor_forward_out;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass step late");
  property p_rev_drop;
    settings_ready_out && single_pulse_format_out && $rose(reverse_pulse_in)
      && !step_pulse_in |-> ##3 !motor_step_out;
  endproperty
  a_rev_drop: assert property (p_rev_drop) else $error("reverse pin used");
  property p_cur_range;
    settings_ready_out |-> current_pct_out inside {[7'd6:7'd100]};
  endproperty
  a_cur_range: assert property (p_cur_range) else $error("current out of range");
endmodule : stepper_drive_chk
bind stepper_drive_setting_logic stepper_drive_chk u_chk (.clk_in, .reset_in, .rd_strobe_in,
  .forward_pulse_in, .reverse_pulse_in, .step_pulse_in, .rate_smoothing_sel_in, .rd_data_out,
  .settings_ready_out, .steps_per_rev_out, .single_pulse_format_out, .current_pct_out,
  .motor_step_out, .motor_forward_out);

// [sim/controller_model.sv]
`timescale 1ns/1ns
module controller_model (
  input wire logic clk_in,
  input wire logic fire_in,
  input wire logic [1:0] kind_in,
  output logic forward_pulse_out,
  output logic reverse_pulse_out,
  output logic step_pulse_out,
  output logic direction_out
);
  logic fire_q;
  logic [1:0] kind_q;
  // ========
  // pulse drive
  // direction settles a cycle before the step edge
  always_ff @(posedge clk_in) begin
    fire_q <= fire_in;
    kind_q <= kind_in;
  end
  always_ff @(posedge clk_in) begin
    forward_pulse_out <= fire_q && kind_q == 2'h0;
    reverse_pulse_out <= fire_q && kind_q == 2'h1;
    step_pulse_out <= fire_q && kind_q[1];
  end
  always_ff @(posedge clk_in) begin
    if (fire_in && kind_in[1]) begin
      direction_out <= ~kind_in[0];
    end
  end
endmodule : controller_model

// [sim/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic fine = 1'b1, ten = 1'b0, x10 = 1'b0, fmt = 1'b1, ws = 1'b0, rs = 1'b0, fire = 1'b0;
  logic [3:0] cur = 4'hf, fil = 4'h0, addr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [1:0] kind = 2'h0;
  logic fwdp, revp, stpp, dir, ready, single, mstep, mfwd;
  logic [31:0] rdat;
  logic [13:0] spr;
  logic [6:0] pct;
  int errors = 0;
  int tests_run = 0;
  int i;
  logic [6:0] tbl [16] = '{7'd6, 7'd13, 7'd19, 7'd25, 7'd31, 7'd38, 7'd44, 7'd50,
    7'd56, 7'd63, 7'd69, 7'd75, 7'd81, 7'd88, 7'd94, 7'd100};
  initial forever #25 clk_in = ~clk_in;
  controller_model ctl (.clk_in(clk_in), .fire_in(fire), .kind_in(kind),
    .forward_pulse_out(fwdp), .reverse_pulse_out(revp), .step_pulse_out(stpp),
    .direction_out(dir));
  stepper_drive_setting_logic DUT (.clk_in(clk_in), .reset_in(reset_in),
    .res_fine_sel_in(fine), .base_times_ten_sel_in(ten), .times_ten_in(x10),
    .format_sel_in(fmt), .current_sel_in(cur), .rate_smoothing_sel_in(fil),
    .forward_pulse_in(fwdp), .reverse_pulse_in(revp), .step_pulse_in(stpp),
    .direction_in(dir), .addr_in(addr), .wr_data_in(wdat), .wr_strobe_in(ws),
    .rd_strobe_in(rs), .rd_data_out(rdat), .settings_ready_out(ready),
    .steps_per_rev_out(spr), .single_pulse_format_out(single), .current_pct_out(pct),
    .motor_step_out(mstep), .motor_forward_out(mfwd));
  // ========
  // tasks
  task automatic final_report();
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    ws <= 1'b1; addr <= a; wdat <= d;
    @(posedge clk_in);
    ws <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_in);
    rs <= 1'b1; addr <= a;
    @(posedge clk_in);
    rs <= 1'b0;
    #1 chk(rdat, e);
  endtask : rd
  // waits long enough for the slowest smoothing release used here
  task automatic pulse(input logic [1:0] k, input logic es, input logic ef, input int n);
    logic got;
    logic f;
    got = 1'b0;
    f = 1'b0;
    @(posedge clk_in);
    fire <= 1'b1; kind <= k;
    @(posedge clk_in);
    fire <= 1'b0;
    repeat (n) begin
      @(posedge clk_in);
      #1 if (mstep === 1'b1) begin got = 1'b1; f = mfwd; end
    end
    chk(got, es);
    if (es) chk(f, ef);
  endtask : pulse
  task automatic do_reset(input logic f, input logic t, input logic m);
    int n;
    @(posedge clk_in);
    reset_in <= 1'b1; fine <= f; ten <= t; fmt <= m; x10 <= 1'b0; fil <= 4'h0;
    repeat (5) @(posedge clk_in);
    #1 chk(pct, 7'd100);
    chk(mfwd, 1'b1);
    @(posedge clk_in);
    reset_in <= 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 12) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (ready !== 1'b1) begin errors++; final_report(); end
  endtask : do_reset
  // ========
  // main sequence
  initial begin
    do_reset(1'b1, 1'b0, 1'b1);
    chk(spr, 14'd1000);
    @(posedge clk_in);
    x10 <= 1'b1; fine <= 1'b0; fmt <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1 chk(spr, 14'd10000);
    chk(single, 1'b0);
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in);
      cur <= i[3:0];
      repeat (4) @(posedge clk_in);
      #1 chk(pct, tbl[i]);
    end
    pulse(2'h0, 1'b1, 1'b1, 8);
    pulse(2'h1, 1'b1, 1'b0, 8);
    rd(4'h4, 32'h0030f110);
    wr(4'h4, 32'h0);
    rd(4'h4, 32'h0030f110);
    rd(4'h2, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'hc, 32'h0);
    rd(4'h0, 32'h1);
    @(posedge clk_in);
    x10 <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1 chk(spr, 14'd1000);
    do_reset(1'b0, 1'b1, 1'b0);
    chk(spr, 14'd5000);
    chk(single, 1'b1);
    @(posedge clk_in);
    x10 <= 1'b1;
    repeat (6) @(posedge clk_in);
    #1 chk(spr, 14'd5000);
    pulse(2'h2, 1'b1, 1'b1, 8);
    pulse(2'h3, 1'b1, 1'b0, 8);
    pulse(2'h1, 1'b0, 1'b0, 8);
    wr(4'h0, 32'h0);
    rd(4'h0, 32'h0);
    pulse(2'h2, 1'b0, 1'b0, 8);
    wr(4'h0, 32'h1);
    do_reset(1'b0, 1'b0, 1'b1);
    chk(spr, 14'd500);
    @(posedge clk_in);
    fil <= 4'h1;
    repeat (4) @(posedge clk_in);
    pulse(2'h0, 1'b0, 1'b0, 8);
    pulse(2'h0, 1'b1, 1'b1, 8000);
    final_report();
  end
endmodule : tb_top
